// ### tb/can_cmd_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module can_cmd_asserts (
    input wire logic                              mclk_i,
    input wire logic                              reset_i,
    input wire logic                              msg_valid_i,
    input wire logic [can_cmd_pkg::PAYLOAD_W-1:0] msg_payload_i,
    input wire logic                              rx_error_i,
    input wire can_cmd_pkg::contacts_t            contact_i,
    input wire can_cmd_pkg::reg_req_t             bus_i,
    input wire logic [can_cmd_pkg::DATA_W-1:0]    rd_data_o,
    input wire can_cmd_pkg::requests_t            req_o,
    input wire can_cmd_pkg::link_state_t          link_state_o
);
    import can_cmd_pkg::*;
    logic [3:0] src;
    logic [6:0] pin_req;
    // shadow of the source flags, seen only through bus writes
    always_ff @(posedge mclk_i) begin
        if (reset_i) src <= 4'h0;
        else if (bus_i.wr && bus_i.addr == OFS_SRC_SEL) src <= bus_i.wdata[3:0];
    end
    assign pin_req = {contact_i[3], contact_i[2], contact_i[0], contact_i[2],
                      contact_i[0], contact_i[1], contact_i[3]};
    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    ////////////////////////////////////////////////////////////////////////////
    a_curve_forced: assert property (
        (rx_error_i && src == 4'hF) ##1 (src == 4'hF) |=> req_o[1:0] == 2'h0)
        else $error("curve bits not forced off");
    a_starter_forced: assert property (
        (rx_error_i && src == 4'hF) ##1 (src == 4'hF) |=> !req_o.starter_disable)
        else $error("starter not forced to enable");
    a_mode_kept: assert property (
        (rx_error_i && src == 4'hF) ##1 (rx_error_i && src == 4'hF)
        |=> $stable({req_o[6:5], req_o[3:2]}))
        else $error("mode or idle changed under error");
    a_msg_applied: assert property (
        (msg_valid_i && !rx_error_i && src == 4'hF) ##1 (src == 4'hF)
        |=> req_o == $past(msg_payload_i[6:0], 2))
        else $error("message not applied");
    a_contact_path: assert property (
        src == 4'h0 [*4] |-> req_o == $past(pin_req, 3))
        else $error("contact path wrong");
    a_init_disable: assert property (
        (link_state_o == ST_INIT && src == 4'hF && $past(src) == 4'hF) |-> req_o == 7'h10)
        else $error("initial requests wrong");
    a_src_readback: assert property (
        (bus_i.rd && bus_i.addr == OFS_SRC_SEL) |=> rd_data_o == {28'h0, $past(src)})
        else $error("source flags read wrong");
    a_eff_readback: assert property (
        (bus_i.rd && bus_i.addr == OFS_EFFECTIVE) |=> rd_data_o == {25'h0, $past(req_o)})
        else $error("effective read wrong");
endmodule : can_cmd_asserts
`default_nettype wire

// ### tb/can_controller_model.sv
`timescale 1ns/10ps
`default_nettype none
module can_controller_model (
    input  wire logic                              mclk_i,
    output logic                                   msg_valid_o,
    output logic [can_cmd_pkg::PAYLOAD_W-1:0]      msg_payload_o,
    output logic                                   rx_error_o
);
    import can_cmd_pkg::*;
    logic [7:0] seq;
    initial begin
        msg_valid_o = 1'b0;
        msg_payload_o = '0;
        rx_error_o = 1'b0;
        seq = 8'h00;
    end
    task automatic send(input logic [7:0] byte1);
        @(posedge mclk_i);
        seq = seq + 8'h01;
        msg_valid_o <= 1'b1;
        msg_payload_o <= {{7{seq}}, byte1};
        @(posedge mclk_i);
        msg_valid_o <= 1'b0;
        // released bus: never leave the last value standing
        msg_payload_o <= ~{{7{seq}}, byte1};
    endtask : send
    task automatic set_error(input logic on);
        @(posedge mclk_i);
        rx_error_o <= on;
    endtask : set_error
endmodule : can_controller_model
`default_nettype wire

// ### tb/can_operating_command_decoder_tb.sv
`timescale 1ns/10ps
`default_nettype none
module can_operating_command_decoder_tb;
    import can_cmd_pkg::*;
    typedef struct packed {
        logic [3:0] src;
        logic [3:0] pins;
        logic [7:0] byte1;
        logic [6:0] exp;
    } row_t;
    logic                 mclk_i;
    logic                 reset_i;
    logic                 msg_valid_i;
    logic                 rx_error_i;
    logic [PAYLOAD_W-1:0] msg_payload_i;
    contacts_t            contact_i;
    reg_req_t             bus_i;
    logic [DATA_W-1:0]    rd_data_o;
    requests_t            req_o;
    link_state_t          link_state_o;
    int                   errors;
    int                   samples_checked;
    row_t                 rows [12];
    logic [31:0]          d;

    can_operating_command_decoder uut (.mclk_i(mclk_i), .reset_i(reset_i),
        .msg_valid_i(msg_valid_i), .msg_payload_i(msg_payload_i), .rx_error_i(rx_error_i),
        .contact_i(contact_i), .bus_i(bus_i), .rd_data_o(rd_data_o), .req_o(req_o),
        .link_state_o(link_state_o));
    can_controller_model ctl (.mclk_i(mclk_i), .msg_valid_o(msg_valid_i),
        .msg_payload_o(msg_payload_i), .rx_error_o(rx_error_i));

    initial begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk_i);
        bus_i <= '{a, v, 1'b1, 1'b0};
        @(posedge mclk_i);
        bus_i <= '{a, v, 1'b0, 1'b0};
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk_i);
        bus_i <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge mclk_i);
        bus_i <= '{a, 32'h0, 1'b0, 1'b0};
        #1 v = rd_data_o;
    endtask : rd
    // checks after a tick see what the last edge launched
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : tick
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        reset_i = 1'b1;
        contact_i = '0;
        bus_i = '0;
        errors = 0;
        samples_checked = 0;
        rows = '{'{4'hF, 4'h0, 8'h01, 7'h01}, '{4'hF, 4'h0, 8'h02, 7'h02},
                 '{4'hF, 4'h0, 8'h04, 7'h04}, '{4'hF, 4'h0, 8'h08, 7'h08},
                 '{4'hF, 4'h0, 8'h10, 7'h10}, '{4'hF, 4'h0, 8'h20, 7'h20},
                 '{4'hF, 4'h0, 8'h40, 7'h40}, '{4'hF, 4'h0, 8'hFF, 7'h7F},
                 '{4'hF, 4'h0, 8'h00, 7'h00}, '{4'h0, 4'hF, 8'h7F, 7'h7F},
                 '{4'h0, 4'h1, 8'h00, 7'h14}, '{4'h6, 4'h8, 8'h2A, 7'h6B}};
        tick(15);
        @(posedge mclk_i);
        reset_i <= 1'b0;
        rd(OFS_EFFECTIVE, d);
        check(d, 32'h0);
        wr(OFS_SRC_SEL, 32'hF);
        tick(2);
        check(req_o, 7'h10);
        rd(OFS_SRC_SEL, d);
        check(d, 32'hF);
        $display("reset test done");
        for (int i = 0; i < 12; i++) begin
            wr(OFS_SRC_SEL, {28'h0, rows[i].src});
            contact_i <= rows[i].pins;
            ctl.send(rows[i].byte1);
            tick(4);
            check(req_o, rows[i].exp);
            rd(OFS_EFFECTIVE, d);
            check(d, {25'h0, rows[i].exp});
            $display("row %0d done", i);
        end
        // error mid-run: forced bits, kept bits, dropped message, recovery
        wr(OFS_SRC_SEL, 32'hF);
        contact_i <= '0;
        ctl.send(8'h7F);
        tick(3);
        check(link_state_o, ST_RUN);
        ctl.set_error(1'b1);
        tick(3);
        check(req_o, 7'h6C);
        check(link_state_o, ST_FAULT);
        ctl.send(8'h00);
        tick(3);
        check(req_o, 7'h6C);
        rd(OFS_STATUS, d);
        check(d, 32'hB);
        rd(OFS_DROP_CNT, d);
        check(d, 32'h1);
        rd(OFS_CAN_REQ, d);
        check(d, 32'h6C);
        ctl.set_error(1'b0);
        tick(3);
        check(req_o, 7'h6C);
        ctl.send(8'h15);
        tick(3);
        check(req_o, 7'h15);
        rd(OFS_LAST_BYTE, d);
        check(d, 32'h15);
        rd(OFS_MSG_COUNT, d);
        check(d, 32'hE);
        wr(OFS_MSG_COUNT, 32'h0);
        rd(OFS_MSG_COUNT, d);
        check(d, 32'h0);
        rd(8'h1C, d);
        check(d, 32'h0);
        $display("error test done");
        @(posedge mclk_i);
        reset_i <= 1'b1;
        tick(2);
        @(posedge mclk_i);
        reset_i <= 1'b0;
        tick(2);
        check(link_state_o, ST_INIT);
        rd(OFS_CAN_REQ, d);
        check(d, 32'h10);
        rd(OFS_SRC_SEL, d);
        check(d, 32'h0);
        $display("second reset test done");
        final_report();
    end
    // bounds the whole run; a hang ends as a mismatch
    initial begin
        tick(20000);
        errors++;
        $display("unexpected at %0t: run too long", $time);
        final_report();
    end
endmodule : can_operating_command_decoder_tb
bind can_operating_command_decoder can_cmd_asserts chk (.mclk_i(mclk_i), .reset_i(reset_i),
    .msg_valid_i(msg_valid_i), .msg_payload_i(msg_payload_i), .rx_error_i(rx_error_i),
    .contact_i(contact_i), .bus_i(bus_i), .rd_data_o(rd_data_o), .req_o(req_o),
    .link_state_o(link_state_o));
`default_nettype wire

// ### verilog/can_cmd_pkg.sv
`default_nettype none
package can_cmd_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register port geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0] OFS_SRC_SEL   = 8'h00;
    localparam logic [7:0] OFS_CAN_REQ   = 8'h04;
    localparam logic [7:0] OFS_EFFECTIVE = 8'h08;
    localparam logic [7:0] OFS_STATUS    = 8'h0C;
    localparam logic [7:0] OFS_LAST_BYTE = 8'h10;
    localparam logic [7:0] OFS_MSG_COUNT = 8'h14;
    localparam logic [7:0] OFS_DROP_CNT  = 8'h18;

    ////////////////////////////////////////////////////////////////////////////
    // payload byte 1 field positions (bit 1 of the byte is bit 0 here)
    localparam int BIT_CURVE_ONE  = 0;
    localparam int BIT_CURVE_TWO  = 1;
    localparam int BIT_DROOP      = 2;
    localparam int BIT_REV_DROOP  = 3;
    localparam int BIT_STARTER    = 4;
    localparam int BIT_IDLE_FIVE  = 5;
    localparam int BIT_IDLE_SEVEN = 6;
    localparam int BYTE1_LSB      = 0;
    localparam int BYTE1_W        = 8;
    localparam int PAYLOAD_W      = 64;

    ////////////////////////////////////////////////////////////////////////////
    // source select flags, one per contact input; 1 selects can
    localparam int SRC_ONE   = 0;
    localparam int SRC_TWO   = 1;
    localparam int SRC_FIVE  = 2;
    localparam int SRC_SEVEN = 3;

    ////////////////////////////////////////////////////////////////////////////
    // status register field positions
    localparam int STS_RX_ERROR = 0;
    localparam int STS_SEEN     = 1;
    localparam int STS_STATE    = 2;
    localparam int STS_CONTACT  = 4;

    ////////////////////////////////////////////////////////////////////////////
    // reset and fault values
    localparam logic [3:0]  SRC_SEL_RESET   = 4'h0;
    localparam logic [7:0]  LAST_BYTE_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET     = 16'h0000;
    localparam logic [6:0]  REQ_RESET       = 7'h10;
    localparam logic        STARTER_RESET   = 1'b1;
    localparam logic        STARTER_FAULT   = 1'b0;
    localparam logic        CURVE_FAULT     = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef struct packed {
        logic high_idle_seven;
        logic high_idle_five;
        logic starter_disable;
        logic reverse_droop;
        logic droop;
        logic curve_two;
        logic curve_one;
    } requests_t;

    typedef struct packed {
        logic contact_input_seven;
        logic contact_input_five;
        logic contact_input_two;
        logic contact_input_one;
    } contacts_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_t;

    typedef enum logic [1:0] {
        ST_INIT  = 2'b00,
        ST_RUN   = 2'b01,
        ST_FAULT = 2'b10
    } link_state_t;

endpackage : can_cmd_pkg
`default_nettype wire

// ### verilog/can_operating_command_decoder.sv
`timescale 1ns/10ps
`default_nettype none
//
// Behaviour
// - curve selection: two bits from byte bit 1
// - bit 1 is curve one, for input seven
// - bit 2 is curve two, for input two
// - reception error forces both curve bits off
// - bits 3/4: droop (one), reverse droop (five)
// - bit 5 starter restraint, 1 disables, input one
// - starter held disabled until first valid message or reception error
// - reception error forces starter to enable
// - bits 6/7 high idle, inputs five and seven
// - other requests off until first valid message
// - error keeps governing mode and high idle
// - after error clears, new messages apply again
// - can replaces contact only when flag selects it
module can_operating_command_decoder (
    input  wire logic                               mclk_i,
    input  wire logic                               reset_i,
    input  wire logic                               msg_valid_i,
    input  wire logic [can_cmd_pkg::PAYLOAD_W-1:0]  msg_payload_i,
    input  wire logic                               rx_error_i,
    input  wire can_cmd_pkg::contacts_t             contact_i,
    input  wire can_cmd_pkg::reg_req_t              bus_i,
    output logic      [can_cmd_pkg::DATA_W-1:0]     rd_data_o,
    output can_cmd_pkg::requests_t                  req_o,
    output can_cmd_pkg::link_state_t                link_state_o
);
    import can_cmd_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // pick the can bit when the input's source flag says can
    function automatic logic pick_source(input logic can_bit,
                                         input logic contact_bit,
                                         input logic use_can);
        pick_source = use_can ? can_bit : contact_bit;
    endfunction : pick_source

    // counter step: clear first, then count, so an event in the clear
    // cycle is not lost; wraps at 16 bits
    function automatic logic [15:0] count_step(input logic [15:0] value,
                                               input logic        inc,
                                               input logic        clr);
        logic [15:0] base;
        base = clr ? COUNT_RESET : value;
        count_step = inc ? 16'(base + 16'h0001) : base;
    endfunction : count_step

    // one offset compare, shared by the write decodes
    function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                      input logic [ADDR_W-1:0] offset);
        addr_hit = addr == offset;
    endfunction : addr_hit

    ////////////////////////////////////////////////////////////////////////////
    // contact pins come from outside the clock domain

    contacts_t contact_sync;

    // contacts are levels; a pulse shorter than a clock may be missed
    pin_synchroniser #(
        .WIDTH   (4)
    ) u_contact_sync (
        .mclk_i  (mclk_i),
        .reset_i (reset_i),
        .async_i (contact_i),
        .sync_o  (contact_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // state

    logic [3:0]  src_sel;
    requests_t   can_req;
    logic [7:0]  last_byte;
    logic [15:0] msg_count;
    logic [15:0] drop_count;
    logic        seen_valid;
    link_state_t state;
    link_state_t next_state;

    ////////////////////////////////////////////////////////////////////////////
    // message acceptance

    wire logic [BYTE1_W-1:0] byte1;
    wire logic               accept;
    wire logic               drop;

    // only byte 1 is looked at, and bit 8 of it is never decoded
    assign byte1  = msg_payload_i[BYTE1_LSB +: BYTE1_W];
    // a message that lands while the error stands is dropped, so the
    // forced values cannot be overwritten behind the error's back
    assign accept = msg_valid_i & ~rx_error_i;
    // dropped messages are still counted, so lost traffic stays visible
    assign drop   = msg_valid_i & rx_error_i;

    ////////////////////////////////////////////////////////////////////////////
    // field decode

    wire logic rx_curve_one;
    wire logic rx_curve_two;
    wire logic rx_droop;
    wire logic rx_rev_droop;
    wire logic rx_starter;
    wire logic rx_idle_five;
    wire logic rx_idle_seven;

    assign rx_curve_one  = byte1[BIT_CURVE_ONE];
    assign rx_curve_two  = byte1[BIT_CURVE_TWO];
    assign rx_droop      = byte1[BIT_DROOP];
    assign rx_rev_droop  = byte1[BIT_REV_DROOP];
    assign rx_starter    = byte1[BIT_STARTER];
    assign rx_idle_five  = byte1[BIT_IDLE_FIVE];
    assign rx_idle_seven = byte1[BIT_IDLE_SEVEN];

    ////////////////////////////////////////////////////////////////////////////
    // next value of the can-side request image

    requests_t next_can_req;

    always_comb begin
        next_can_req = can_req;
        if (rx_error_i) begin
            // curve and starter take their fault values and keep them
            // after the error goes, until a fresh message arrives
            next_can_req.curve_one       = CURVE_FAULT;
            next_can_req.curve_two       = CURVE_FAULT;
            next_can_req.starter_disable = STARTER_FAULT;
            // governing mode and high idle are left as they were
        end else if (accept) begin
            next_can_req.curve_one       = rx_curve_one;
            next_can_req.curve_two       = rx_curve_two;
            next_can_req.droop           = rx_droop;
            next_can_req.reverse_droop   = rx_rev_droop;
            next_can_req.starter_disable = rx_starter;
            next_can_req.high_idle_five  = rx_idle_five;
            next_can_req.high_idle_seven = rx_idle_seven;
        end
    end

    // the image starts with the starter held off; a pin-sourced input
    // ignores this, its contact governs from the first edge on
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            can_req <= requests_t'(REQ_RESET);
        end else begin
            can_req <= next_can_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // link state: init until first good message or reception error, fault while error stands
    // init is left for good; only reset, or a stray state code through the default branch, brings it back

    always_comb begin
        case (state)
            ST_INIT: begin
                if (rx_error_i) begin
                    next_state = ST_FAULT;
                end else if (accept) begin
                    next_state = ST_RUN;
                end else begin
                    next_state = ST_INIT;
                end
            end
            ST_RUN: begin
                next_state = rx_error_i ? ST_FAULT : ST_RUN;
            end
            ST_FAULT: begin
                next_state = rx_error_i ? ST_FAULT : ST_RUN;
            end
            default: begin
                // a stray code waits again for a good message
                next_state = ST_INIT;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state <= ST_INIT;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            seen_valid <= 1'b0;
        end else if (accept) begin
            seen_valid <= 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            last_byte <= LAST_BYTE_RESET;
        end else if (accept) begin
            last_byte <= byte1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // source selection against the contact pins

    wire logic use_can_one;
    wire logic use_can_two;
    wire logic use_can_five;
    wire logic use_can_seven;

    assign use_can_one   = src_sel[SRC_ONE];
    assign use_can_two   = src_sel[SRC_TWO];
    assign use_can_five  = src_sel[SRC_FIVE];
    assign use_can_seven = src_sel[SRC_SEVEN];

    requests_t next_req;

    // each function keeps the contact that it stands in for
    // a flag change switches a whole input over at one edge
    assign next_req.curve_one = pick_source(can_req.curve_one,
        contact_sync.contact_input_seven, use_can_seven);
    assign next_req.curve_two = pick_source(can_req.curve_two,
        contact_sync.contact_input_two, use_can_two);
    assign next_req.droop = pick_source(can_req.droop,
        contact_sync.contact_input_one, use_can_one);
    assign next_req.reverse_droop = pick_source(can_req.reverse_droop,
        contact_sync.contact_input_five, use_can_five);
    assign next_req.starter_disable = pick_source(can_req.starter_disable,
        contact_sync.contact_input_one, use_can_one);
    assign next_req.high_idle_five = pick_source(can_req.high_idle_five,
        contact_sync.contact_input_five, use_can_five);
    assign next_req.high_idle_seven = pick_source(can_req.high_idle_seven,
        contact_sync.contact_input_seven, use_can_seven);

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            req_o <= requests_t'(REQ_RESET);
        end else begin
            req_o <= next_req;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            link_state_o <= ST_INIT;
        end else begin
            link_state_o <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register port

    wire logic hit_src_sel;
    wire logic hit_msg_count;
    wire logic hit_drop_cnt;
    wire logic wr_src_sel;
    wire logic clr_msg_count;
    wire logic clr_drop_cnt;

    assign hit_src_sel   = addr_hit(bus_i.addr, OFS_SRC_SEL);
    assign hit_msg_count = addr_hit(bus_i.addr, OFS_MSG_COUNT);
    assign hit_drop_cnt  = addr_hit(bus_i.addr, OFS_DROP_CNT);
    assign wr_src_sel    = bus_i.wr & hit_src_sel;
    // any write to a counter clears it; a same-cycle count still lands
    assign clr_msg_count = bus_i.wr & hit_msg_count;
    assign clr_drop_cnt  = bus_i.wr & hit_drop_cnt;

    // only the low four bits are flags; the rest of the word is dropped
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            src_sel <= SRC_SEL_RESET;
        end else if (wr_src_sel) begin
            src_sel <= bus_i.wdata[3:0];
        end
    end

    wire logic [15:0] next_msg_count;
    wire logic [15:0] next_drop_count;

    assign next_msg_count  = count_step(msg_count, accept, clr_msg_count);
    assign next_drop_count = count_step(drop_count, drop, clr_drop_cnt);

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            msg_count <= COUNT_RESET;
        end else begin
            msg_count <= next_msg_count;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            drop_count <= COUNT_RESET;
        end else begin
            drop_count <= next_drop_count;
        end
    end

    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] next_rd_data;

    // contacts show as the logic sees them, after the synchroniser
    always_comb begin
        status_word = '0;
        status_word[STS_RX_ERROR] = rx_error_i;
        status_word[STS_SEEN] = seen_valid;
        status_word[STS_STATE +: 2] = state;
        status_word[STS_CONTACT +: 4] = contact_sync;
    end

    // unmapped addresses read as zero
    // narrow registers read back zero-extended
    always_comb begin
        next_rd_data = '0;
        if (bus_i.rd) begin
            case (bus_i.addr)
                OFS_SRC_SEL:   next_rd_data = {28'h0000000, src_sel};
                OFS_CAN_REQ:   next_rd_data = {25'h0000000, can_req};
                OFS_EFFECTIVE: next_rd_data = {25'h0000000, req_o};
                OFS_STATUS:    next_rd_data = status_word;
                OFS_LAST_BYTE: next_rd_data = {24'h000000, last_byte};
                OFS_MSG_COUNT: next_rd_data = {16'h0000, msg_count};
                OFS_DROP_CNT:  next_rd_data = {16'h0000, drop_count};
                default:       next_rd_data = '0;
            endcase
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            rd_data_o <= '0;
        end else begin
            rd_data_o <= next_rd_data;
        end
    end

endmodule : can_operating_command_decoder
`default_nettype wire

// ### verilog/pin_synchroniser.sv
`timescale 1ns/10ps
`default_nettype none
module pin_synchroniser #(
    parameter int WIDTH = 4
) (
    input  wire logic             mclk_i,
    input  wire logic             reset_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    // first stage is read only by the second stage
    logic [WIDTH-1:0] meta;

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            meta   <= '0;
            sync_o <= '0;
        end else begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end

endmodule : pin_synchroniser
`default_nettype wire
